// ==== rtl/pfrs_regs.svh ====
`ifndef PFRS_REGS_SVH
`define PFRS_REGS_SVH
// ==========================================================================
// Vector addresses
`define PFRS_VEC_PFAIL 16'h001c
`define PFRS_VEC_OFFSET 16'h0100
`define PFRS_VEC_RESTART 16'h0000
// ==========================================================================
// Grace period timing
`define PFRS_CLK_HZ 50000000
`define PFRS_GRACE_US 900
`define PFRS_GRACE_CYC ((`PFRS_GRACE_US * (`PFRS_CLK_HZ / 1000000)))
`define PFRS_TMR_W 16
`endif

// ==== rtl/pfrs_pkg.sv ====
package pfrs_pkg;
	typedef enum logic [2:0] {
		PFRS_ST_DOWN,
		PFRS_ST_RUN,
		PFRS_ST_IRQ,
		PFRS_ST_GRACE,
		PFRS_ST_HALT
	} pfrs_state_t;

	// Option straps, already at the clock's level
	typedef struct packed {
		logic auto_startup_option;
		logic irq_independence_strap_n;
		logic high_prio_vector_offset_n;
	} pfrs_cfg_t;

	// Instruction strobes from the core
	typedef struct packed {
		logic powerfail_irq_enable_instr;
		logic powerfail_irq_disable_instr;
		logic global_irq_enable_instr;
		logic global_irq_disable_instr;
	} pfrs_instr_t;

	typedef struct packed {
		pfrs_state_t st;
		logic [1:0] fail_sync;
		logic [1:0] good_sync;
		logic pf_en;
		logic glb_en;
		logic irq;
		logic [15:0] vector;
		logic halt;
		logic mem_protect;
		logic load_pc;
		logic [15:0] pc_value;
		logic run;
		logic [15:0] tmr;
	} pfrs_state_s_t;
endpackage

// ==== rtl/pfrs_seq.sv ====
// How it works
// - Power loss raises interrupt request
// - Vector 001C, or 011C when offset
// - Halt and protect 0.9 ms after handler
// - Power back: memory on, PC zero, run
// - Restart every power-up from address zero
// - Option fitted: only dedicated instructions gate
// - Otherwise global enable gates, dedicated ignored
// - Auto start-up raises no interrupt
// - Auto start-up otherwise restarts identically
// - Strap low makes interrupt independent
// - Offset strap low adds 100 to vector
`timescale 1ns/100ps
`include "pfrs_regs.svh"
module pfrs_seq
	import pfrs_pkg::*;
(
	input wire logic CLK,
	input wire logic SRST,
	input wire logic POWER_FAIL,
	input wire logic POWER_GOOD,
	input wire pfrs_cfg_t CFG,
	input wire pfrs_instr_t INSTR,
	input wire logic IRQ_ACK,
	output logic PF_IRQ,
	output logic [15:0] PF_VECTOR,
	output logic HALT,
	output logic MEM_PROTECT,
	output logic LOAD_PC,
	output logic [15:0] PC_VALUE,
	output logic RUN
);
	localparam logic [15:0] GRACE_CYC = 16'(`PFRS_GRACE_CYC);

	pfrs_state_s_t s_reg;
	pfrs_state_s_t s_next;
	logic fail_s;
	logic good_s;
	logic gate_open;

	// ==========================================================================
	// Next-state logic
	always_comb
	begin
		s_next = s_reg;
		s_next.load_pc = 1'b0;
		// Second stage only is read downstream
		s_next.fail_sync = {s_reg.fail_sync[0], POWER_FAIL};
		s_next.good_sync = {s_reg.good_sync[0], POWER_GOOD};
		fail_s = s_reg.fail_sync[1];
		good_s = s_reg.good_sync[1];
		// Enable latches follow instruction strobes; enable wins a tie
		if (INSTR.powerfail_irq_disable_instr)
			s_next.pf_en = 1'b0;
		if (INSTR.powerfail_irq_enable_instr)
			s_next.pf_en = 1'b1;
		if (INSTR.global_irq_disable_instr)
			s_next.glb_en = 1'b0;
		if (INSTR.global_irq_enable_instr)
			s_next.glb_en = 1'b1;
		// Strap picks which enable gates the request
		if (!CFG.irq_independence_strap_n)
			gate_open = s_reg.pf_en;
		else
			gate_open = s_reg.glb_en;
		unique case (s_reg.st)
			PFRS_ST_DOWN:
			begin
				s_next.mem_protect = 1'b1;
				s_next.halt = 1'b1;
				s_next.run = 1'b0;
				if (good_s && !fail_s)
				begin
					// Same sequence on every power application
					s_next.mem_protect = 1'b0;
					s_next.halt = 1'b0;
					s_next.load_pc = 1'b1;
					s_next.pc_value = `PFRS_VEC_RESTART;
					s_next.run = 1'b1;
					s_next.st = PFRS_ST_RUN;
				end
			end
			PFRS_ST_RUN:
			begin
				if (fail_s)
				begin
					if (CFG.auto_startup_option)
					begin
						// No handler, so halt without grace
						s_next.st = PFRS_ST_HALT;
					end
					else
					begin
						s_next.vector = `PFRS_VEC_PFAIL;
						if (!CFG.high_prio_vector_offset_n)
							s_next.vector = `PFRS_VEC_PFAIL + `PFRS_VEC_OFFSET;
						s_next.st = PFRS_ST_IRQ;
					end
				end
			end
			PFRS_ST_IRQ:
			begin
				// Request follows the gate until the core takes it
				s_next.irq = gate_open;
				if (s_reg.irq && IRQ_ACK)
				begin
					s_next.irq = 1'b0;
					s_next.tmr = GRACE_CYC;
					s_next.st = PFRS_ST_GRACE;
				end
				else if (good_s && !fail_s)
				begin
					// Glitch recovered before service; keep running
					s_next.irq = 1'b0;
					s_next.st = PFRS_ST_RUN;
				end
			end
			PFRS_ST_GRACE:
			begin
				s_next.tmr = s_reg.tmr - 16'h0001;
				if (s_reg.tmr == 16'h0001)
					s_next.st = PFRS_ST_HALT;
			end
			PFRS_ST_HALT:
			begin
				s_next.run = 1'b0;
				s_next.halt = 1'b1;
				s_next.mem_protect = 1'b1;
				s_next.st = PFRS_ST_DOWN;
			end
		endcase
	end

	// ==========================================================================
	// State register
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			s_reg <= '0;
			s_reg.st <= PFRS_ST_DOWN;
			s_reg.halt <= 1'b1;
			s_reg.mem_protect <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign PF_IRQ = s_reg.irq;
	assign PF_VECTOR = s_reg.vector;
	assign HALT = s_reg.halt;
	assign MEM_PROTECT = s_reg.mem_protect;
	assign LOAD_PC = s_reg.load_pc;
	assign PC_VALUE = s_reg.pc_value;
	assign RUN = s_reg.run;

	// ==========================================================================
	// Grace watch: cycles since the core took the request
	// A plain counter, since a delay range this long would stall the checker
	logic grace_on;
	logic [15:0] grace_cnt;
	localparam logic [15:0] GRACE_END = 16'(`PFRS_GRACE_CYC + 1);

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			grace_on <= 1'b0;
			grace_cnt <= 16'h0000;
		end
		else if (PF_IRQ && IRQ_ACK)
		begin
			grace_on <= 1'b1;
			grace_cnt <= 16'h0000;
		end
		else if (grace_on)
		begin
			grace_cnt <= grace_cnt + 16'h0001;
			if (HALT)
				grace_on <= 1'b0; // Watch ends once the halt is seen
		end
	end

	// ==========================================================================
	// Checks
	sequence seq_acked;
		PF_IRQ && IRQ_ACK;
	endsequence
	sequence seq_protected;
		HALT && MEM_PROTECT && !RUN;
	endsequence

	a_restart_pc_zero: assert property (@(posedge CLK) disable iff (SRST)
		LOAD_PC |-> (PC_VALUE == 16'h0000) && RUN && !MEM_PROTECT)
		else $error("restart without pc zero or run");
	a_grace_halts: assert property (@(posedge CLK) disable iff (SRST)
		grace_on && HALT |-> (grace_cnt == GRACE_END) ##0 seq_protected)
		else $error("halt not after grace period");
	a_grace_bound: assert property (@(posedge CLK) disable iff (SRST)
		grace_on |-> grace_cnt <= GRACE_END)
		else $error("no halt after grace period");
	a_asu_no_irq: assert property (@(posedge CLK) disable iff (SRST)
		CFG.auto_startup_option && $stable(CFG) |-> !$rose(PF_IRQ))
		else $error("interrupt raised in auto start-up");
	a_vector_base: assert property (@(posedge CLK) disable iff (SRST)
		PF_IRQ && CFG.high_prio_vector_offset_n && $stable(CFG) |-> PF_VECTOR == 16'h001c)
		else $error("wrong base vector");
	a_vector_offset: assert property (@(posedge CLK) disable iff (SRST)
		PF_IRQ && !CFG.high_prio_vector_offset_n && $stable(CFG) |-> PF_VECTOR == 16'h011c)
		else $error("wrong offset vector");
	a_gate_indep: assert property (@(posedge CLK) disable iff (SRST)
		$rose(PF_IRQ) && !CFG.irq_independence_strap_n |-> $past(s_reg.pf_en))
		else $error("independent irq raised while disabled");
	a_gate_global: assert property (@(posedge CLK) disable iff (SRST)
		$rose(PF_IRQ) && CFG.irq_independence_strap_n |-> $past(s_reg.glb_en))
		else $error("irq raised with global disabled");
	a_power_up_run: assert property (@(posedge CLK) disable iff (SRST)
		(s_reg.st == PFRS_ST_DOWN) && good_s && !fail_s |=> LOAD_PC ##1 RUN)
		else $error("no restart on power return");
	a_fail_irq: assert property (@(posedge CLK) disable iff (SRST)
		(s_reg.st == PFRS_ST_IRQ) && gate_open && !IRQ_ACK && fail_s |=> PF_IRQ)
		else $error("fail not requested");
	a_ack_clears: assert property (@(posedge CLK) disable iff (SRST)
		seq_acked |=> !PF_IRQ)
		else $error("request stands after ack");
	a_halt_protects: assert property (@(posedge CLK) disable iff (SRST)
		$rose(HALT) |-> seq_protected)
		else $error("halt without memory protection");
endmodule

// ==== testbench/pfrs_core_model.sv ====
`timescale 1ns/100ps
// ==========================================================================
// Core side: acknowledges a pending request a few cycles later
module pfrs_core_model
(
	input wire logic clk,
	input wire logic pf_irq,
	input wire logic ack_en,
	output logic irq_ack
);
	int n = 0;
	initial irq_ack = 1'b0;
	// Slow answer on purpose, so the request must stand meanwhile
	always @(negedge clk)
	begin
		n = (pf_irq === 1'b1 && ack_en) ? n + 1 : 0;
		irq_ack <= (n == 5);
	end
endmodule

// ==== testbench/test_pfrs_seq.sv ====
`timescale 1ns/100ps
module test_pfrs_seq;
	import pfrs_pkg::*;
	logic clk = 0, srst = 1, fail = 0, good = 0, ack_en = 1;
	pfrs_cfg_t cfg = 3'h3;
	pfrs_instr_t ins = '0;
	logic ack, irq, halt, mp, lp, run;
	logic [15:0] vec, pcv;
	int errors = 0, comparisons = 0, n;
	wire logic [2:0] ev = {halt, irq, lp};
	pfrs_seq dut (.CLK(clk), .SRST(srst), .POWER_FAIL(fail), .POWER_GOOD(good), .CFG(cfg),
		.INSTR(ins), .IRQ_ACK(ack), .PF_IRQ(irq), .PF_VECTOR(vec), .HALT(halt),
		.MEM_PROTECT(mp), .LOAD_PC(lp), .PC_VALUE(pcv), .RUN(run));
	pfrs_core_model core (.clk(clk), .pf_irq(irq), .ack_en(ack_en), .irq_ack(ack));
	initial forever #10 clk = ~clk;
	// ==========================================================================
	// Shared tasks
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
			begin
			errors++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
			end
	endtask
	task end_sim;
		$display("%0d comparisons, %0d errors", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Bounded wait on load, request or halt; a hang ends the run
	task wfor(input int s, input int lim);
		n = 0;
		while (ev[s] !== 1'b1 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= lim)
		begin
			errors++;
			$display("mismatch at %0t: wait timed out", $time);
			end_sim;
		end
	endtask
	task pulse(input pfrs_instr_t v);
		ins = v;
		@(negedge clk);
		ins = '0;
	endtask
	// Covers the synchroniser delay, so a late request is caught too
	task quiet;
		repeat (10)
		begin
			@(negedge clk);
			chk(irq, 1'h0);
		end
	endtask
	// ==========================================================================
	// Scenarios
	task t_restart;
		fail = 0;
		good = 1;
		wfor(0, 20);
		chk({run, halt, mp}, 3'h4);
		chk(pcv, 16'h0000);
		@(negedge clk);
		chk(lp, 1'h0);
		$display("done restart");
	endtask
	task t_grace;
		fail = 1;
		good = 0;
		pulse(4'h8);
		quiet;
		pulse(4'h2);
		wfor(1, 5);
		chk(vec, 16'h001c);
		wfor(2, 46000);
		chk(n >= 45000 && n <= 45012, 1'h1);
		chk({run, halt, mp}, 3'h3);
		$display("done grace");
	endtask
	task t_asu;
		cfg = 3'h7;
		fail = 1;
		good = 0;
		wfor(2, 10);
		chk(irq, 1'h0);
		t_restart;
		$display("done auto start");
	endtask
	task t_offset;
		cfg = 3'h0;
		ack_en = 0;
		pulse(4'h4);
		fail = 1;
		quiet;
		pulse(4'h8);
		wfor(1, 5);
		chk(vec, 16'h011c);
		fail = 0;
		repeat (6) @(negedge clk);
		chk(irq, 1'h0);
		$display("done offset");
	endtask
	// Global disable closes the gate; a tie of enable and disable opens it
	task t_global;
		cfg = 3'h3;
		pulse(4'h1);
		fail = 1;
		quiet;
		pulse(4'h3);
		wfor(1, 5);
		chk(vec, 16'h001c);
		fail = 0;
		repeat (6) @(negedge clk);
		chk(irq, 1'h0);
		$display("done global");
	endtask
	initial
	begin
		repeat (8) @(negedge clk);
		srst = 0;
		chk({run, halt, mp, irq}, 4'h6);
		t_restart;
		t_grace;
		t_restart;
		t_asu;
		t_offset;
		t_global;
		end_sim;
	end
endmodule
